// >>> inc/mrcr_pkg.sv
package mrcr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SOFT_RESET = 8'h03;
    localparam logic [7:0] OFS_HOST_LINK_CONFIG_0 = 8'h04;
    localparam logic [7:0] OFS_CAPABILITY = 8'h02;
    // ------------------------------------------------------------
    // Field positions and resets
    // ------------------------------------------------------------
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_SYNC = 15;
    localparam int BIT_FCS_CHECK = 14;
    localparam int BIT_SEL_ALIGN = 13;
    localparam int BIT_ZERO_ALIGN = 12;
    localparam int BIT_THRESH_LO = 10;
    localparam int BIT_CPS_LO = 0;
    localparam logic [2:0] MIN_CHUNK_EXP_RST = 3'h3;
    localparam logic [2:0] CPS_RST = 3'h6;
    localparam logic [1:0] THRESH_RST = 2'h0;
    localparam logic [7:0] THRESH_1 = 8'h01;
    localparam logic [7:0] THRESH_4 = 8'h04;
    localparam logic [7:0] THRESH_8 = 8'h08;
    localparam logic [7:0] THRESH_16 = 8'h10;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int CS_MIN_HOLD_NS = 100;
    localparam int CS_MIN_HOLD_CYC = (CS_MIN_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] CS_MIN_HOLD_CNT = 4'(CS_MIN_HOLD_CYC);
    typedef enum logic [1:0] {
        MRCR_IDLE = 2'b00,
        MRCR_ARMED = 2'b01,
        MRCR_FIRE = 2'b10
    } mrcr_rst_state_t;
endpackage : mrcr_pkg

// >>> inc/mrcr_rst_if.sv
`timescale 1ns/100ps
interface mrcr_rst_if;
    logic arm;
    logic cs_active;
    logic fire;
    modport ctrl (input arm, input cs_active, output fire);
    modport regs (output arm, output cs_active, input fire);
endinterface : mrcr_rst_if

// >>> design/mrcr_rst_seq.sv
`timescale 1ns/100ps
module mrcr_rst_seq (
    input wire logic clk,
    input wire logic rst_b,
    mrcr_rst_if.ctrl rif
);
    mrcr_pkg::mrcr_rst_state_t state;
    logic [3:0] hold_cnt;
    logic held;

    assign held = (hold_cnt >= mrcr_pkg::CS_MIN_HOLD_CNT);

    // RULE3 wait for deselect
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= mrcr_pkg::MRCR_IDLE;
        end else begin
            case (state)
                mrcr_pkg::MRCR_IDLE: begin
                    if (rif.arm) begin
                        state <= mrcr_pkg::MRCR_ARMED;
                    end
                end
                mrcr_pkg::MRCR_ARMED: begin
                    // RULE4 short select ignored
                    if (!rif.cs_active) begin
                        state <= held ? mrcr_pkg::MRCR_FIRE : mrcr_pkg::MRCR_IDLE;
                    end
                end
                default: begin
                    state <= mrcr_pkg::MRCR_IDLE;
                end
            endcase
        end
    end

    // Counts select time of the current frame
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt <= 4'h0;
        end else if (!rif.cs_active) begin
            hold_cnt <= 4'h0;
        end else if (!held) begin
            hold_cnt <= hold_cnt + 4'h1;
        end
    end

    assign rif.fire = (state == mrcr_pkg::MRCR_FIRE);

    // RULE3 no fire while selected
    property p_fire_after_deselect;
        @(posedge clk) disable iff (!rst_b)
        rif.fire |-> $past(!rif.cs_active);
    endproperty
    a_fire_after_deselect: assert property (p_fire_after_deselect) else $error("reset fired under select"); // RULE3
endmodule : mrcr_rst_seq

// >>> design/mrcr_regs.sv
`timescale 1ns/100ps
// Operation
// RULE1: Capability field min_chunk_size_exp is read-only and resets to 3 (8-byte chunks).
// RULE2: Writing one to soft_reset_trigger resets all registers and state to defaults.
// RULE3: The soft reset is held off until chip select is deasserted.
// RULE4: The host keeps chip select asserted at least 100 ns or the reset is dropped.
// RULE5: soft_reset_trigger clears itself, and bits 31:1 of that register read zero.
// RULE6: The sync bit is copied into every receive chunk footer flag.
// RULE7: The sync bit is write-one-to-set; writing zero leaves it set.
// RULE8: After any reset sync is 0, reset_complete_flag is 1 and the interrupt asserts.
// RULE9: With tx_fcs_check_enable set the last 4 frame octets are checked as FCS.
// RULE10: The host keeps CRC append off while tx_fcs_check_enable is set.
// RULE11: select_aligned_rx_enable starts frames only in the first chunk after select.
// RULE12: zero_aligned_rx_enable starts frames at payload start with offset 0.
// RULE13: The interrupt asserts when free credits reach the coded threshold 1/4/8/16.
// RULE14: Alignment, threshold and min chunk fields apply only under the chunk protocol.
// RULE15: The host sets chunk size before traffic and keeps it fixed once synced.
// RULE16: Reserved bits read zero and ignore writes.
module mrcr_regs (
    CLK_SYS,
    RST_B,
    REG_WR,
    REG_RD,
    REG_ADDR,
    REG_WDATA,
    REG_RDATA,
    CS_ACTIVE,
    CHUNK_PROTOCOL,
    RESET_COMPLETE_CLR,
    TX_CREDIT_COUNT,
    FIRST_CHUNK_AFTER_CS,
    FRAME_START_REQ,
    FRAME_START_OK,
    START_WORD_OFFSET_ZERO,
    FOOTER_SYNC,
    TX_FCS_CHECK_ENABLE,
    FCS_OCTETS,
    CHUNK_SIZE_SELECT,
    RESET_COMPLETE_FLAG,
    SOFT_RESET_OUT,
    IRQ_OUT_N
);
    input wire logic CLK_SYS;
    input wire logic RST_B;
    input wire logic REG_WR;
    input wire logic REG_RD;
    input wire logic [7:0] REG_ADDR;
    input wire logic [31:0] REG_WDATA;
    output logic [31:0] REG_RDATA;
    input wire logic CS_ACTIVE;
    input wire logic CHUNK_PROTOCOL;
    input wire logic RESET_COMPLETE_CLR;
    input wire logic [7:0] TX_CREDIT_COUNT;
    input wire logic FIRST_CHUNK_AFTER_CS;
    input wire logic FRAME_START_REQ;
    output logic FRAME_START_OK;
    output logic START_WORD_OFFSET_ZERO;
    output logic FOOTER_SYNC;
    output logic TX_FCS_CHECK_ENABLE;
    output logic [2:0] FCS_OCTETS;
    output logic [2:0] CHUNK_SIZE_SELECT;
    output logic RESET_COMPLETE_FLAG;
    output logic SOFT_RESET_OUT;
    output logic IRQ_OUT_N;

    // ------------------------------------------------------------
    // Synchronised chip select input and internal reset
    // ------------------------------------------------------------
    logic cs_meta;
    logic cs_sync;
    logic soft_rst_q;
    logic rst_b_int;
    mrcr_rst_if rif ();

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            cs_meta <= 1'b0;
            cs_sync <= 1'b0;
        end else begin
            cs_meta <= CS_ACTIVE;
            cs_sync <= cs_meta;
        end
    end

    // RULE2 full reset pulse
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= rif.fire;
        end
    end

    assign rst_b_int = RST_B & ~soft_rst_q;
    assign SOFT_RESET_OUT = soft_rst_q;
    assign rif.cs_active = cs_sync;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic wr_reset;
    logic wr_cfg;
    logic sync_bit;
    logic fcs_en;
    logic sel_align;
    logic zero_align;
    logic [1:0] thresh;
    logic [2:0] chunk_size_select;
    logic rst_done;
    logic [2:0] min_chunk_size_exp;

    assign wr_reset = REG_WR && (REG_ADDR == mrcr_pkg::OFS_SOFT_RESET);
    assign wr_cfg = REG_WR && (REG_ADDR == mrcr_pkg::OFS_HOST_LINK_CONFIG_0);
    // RULE1 fixed capability
    assign min_chunk_size_exp = mrcr_pkg::MIN_CHUNK_EXP_RST;
    // RULE5 self clearing trigger
    assign rif.arm = wr_reset && REG_WDATA[mrcr_pkg::BIT_SOFT_RESET];

    mrcr_rst_seq u_seq (
        .clk(CLK_SYS),
        .rst_b(rst_b_int),
        .rif(rif.ctrl)
    );

    // RULE7 write one sets
    always_ff @(posedge CLK_SYS or negedge rst_b_int) begin
        if (!rst_b_int) begin
            sync_bit <= 1'b0;
        end else if (wr_cfg && REG_WDATA[mrcr_pkg::BIT_SYNC]) begin
            sync_bit <= 1'b1;
        end
    end

    // RULE16 reserved ignore writes
    always_ff @(posedge CLK_SYS or negedge rst_b_int) begin
        if (!rst_b_int) begin
            fcs_en <= 1'b0;
            sel_align <= 1'b0;
            zero_align <= 1'b0;
            thresh <= mrcr_pkg::THRESH_RST;
            chunk_size_select <= mrcr_pkg::CPS_RST;
        end else if (wr_cfg) begin
            fcs_en <= REG_WDATA[mrcr_pkg::BIT_FCS_CHECK];
            sel_align <= REG_WDATA[mrcr_pkg::BIT_SEL_ALIGN];
            zero_align <= REG_WDATA[mrcr_pkg::BIT_ZERO_ALIGN];
            thresh <= REG_WDATA[mrcr_pkg::BIT_THRESH_LO +: 2];
            chunk_size_select <= REG_WDATA[mrcr_pkg::BIT_CPS_LO +: 3];
        end
    end

    // RULE8 set on any reset
    always_ff @(posedge CLK_SYS or negedge rst_b_int) begin
        if (!rst_b_int) begin
            rst_done <= 1'b1;
        end else if (RESET_COMPLETE_CLR) begin
            rst_done <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0;
        if (REG_ADDR == mrcr_pkg::OFS_HOST_LINK_CONFIG_0) begin
            next_rdata[mrcr_pkg::BIT_SYNC] = sync_bit;
            next_rdata[mrcr_pkg::BIT_FCS_CHECK] = fcs_en;
            next_rdata[mrcr_pkg::BIT_SEL_ALIGN] = sel_align;
            next_rdata[mrcr_pkg::BIT_ZERO_ALIGN] = zero_align;
            next_rdata[mrcr_pkg::BIT_THRESH_LO +: 2] = thresh;
            next_rdata[mrcr_pkg::BIT_CPS_LO +: 3] = chunk_size_select;
        end else if (REG_ADDR == mrcr_pkg::OFS_CAPABILITY) begin
            next_rdata[2:0] = min_chunk_size_exp;
        end
    end

    // RULE5 trigger reads zero
    always_ff @(posedge CLK_SYS or negedge rst_b_int) begin
        if (!rst_b_int) begin
            REG_RDATA <= 32'h0;
        end else if (REG_RD) begin
            REG_RDATA <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Datapath controls
    // ------------------------------------------------------------
    logic [7:0] thresh_val;
    logic credit_ok;
    logic sel_on;
    logic zero_on;

    always_comb begin
        case (thresh)
            2'h0: thresh_val = mrcr_pkg::THRESH_1;
            2'h1: thresh_val = mrcr_pkg::THRESH_4;
            2'h2: thresh_val = mrcr_pkg::THRESH_8;
            default: thresh_val = mrcr_pkg::THRESH_16;
        endcase
    end

    // RULE14 chunk protocol only
    assign sel_on = sel_align && CHUNK_PROTOCOL;
    assign zero_on = zero_align && CHUNK_PROTOCOL;
    // RULE13 credit threshold compare
    assign credit_ok = CHUNK_PROTOCOL && (TX_CREDIT_COUNT >= thresh_val);

    // RULE11 select aligned start
    assign FRAME_START_OK = FRAME_START_REQ && (!sel_on || FIRST_CHUNK_AFTER_CS);
    // RULE12 zero offset start
    assign START_WORD_OFFSET_ZERO = sel_on || zero_on;
    // RULE6 sync into footer
    assign FOOTER_SYNC = sync_bit;
    // RULE9 last four octets
    assign TX_FCS_CHECK_ENABLE = fcs_en;
    assign FCS_OCTETS = fcs_en ? 3'h4 : 3'h0;
    assign CHUNK_SIZE_SELECT = chunk_size_select;
    assign RESET_COMPLETE_FLAG = rst_done;

    // RULE8 interrupt output
    always_ff @(posedge CLK_SYS or negedge rst_b_int) begin
        if (!rst_b_int) begin
            IRQ_OUT_N <= 1'b0;
        end else begin
            IRQ_OUT_N <= ~(rst_done || credit_ok);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_sync_sticky;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        sync_bit |=> sync_bit;
    endproperty
    a_sync_sticky: assert property (p_sync_sticky) else $error("sync bit cleared"); // RULE7

    property p_footer;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        FOOTER_SYNC == sync_bit;
    endproperty
    a_footer: assert property (p_footer) else $error("footer sync mismatch"); // RULE6

    property p_after_reset;
        @(posedge CLK_SYS) $rose(rst_b_int) |-> rst_done && !sync_bit && !IRQ_OUT_N;
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("reset state wrong"); // RULE8

    property p_cap;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        REG_RD && REG_ADDR == mrcr_pkg::OFS_CAPABILITY |=> REG_RDATA == 32'h3;
    endproperty
    a_cap: assert property (p_cap) else $error("capability read wrong"); // RULE1

    property p_rst_reads_zero;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        REG_RD && REG_ADDR == mrcr_pkg::OFS_SOFT_RESET |=> REG_RDATA == 32'h0;
    endproperty
    a_rst_reads_zero: assert property (p_rst_reads_zero) else $error("reset reg nonzero"); // RULE5

    property p_sel_align;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        FRAME_START_OK && sel_on |-> FIRST_CHUNK_AFTER_CS && START_WORD_OFFSET_ZERO;
    endproperty
    a_sel_align: assert property (p_sel_align) else $error("frame start misaligned"); // RULE11

    property p_zero_align;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        zero_on |-> START_WORD_OFFSET_ZERO;
    endproperty
    a_zero_align: assert property (p_zero_align) else $error("offset not zero"); // RULE12

    property p_irq_thresh;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        !rst_done && !$past(rst_done) && !IRQ_OUT_N |-> $past(credit_ok);
    endproperty
    a_irq_thresh: assert property (p_irq_thresh) else $error("irq below threshold"); // RULE13

    property p_fcs;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        TX_FCS_CHECK_ENABLE |-> FCS_OCTETS == 3'h4;
    endproperty
    a_fcs: assert property (p_fcs) else $error("fcs length wrong"); // RULE9

    property p_footer_set;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        wr_cfg && REG_WDATA[mrcr_pkg::BIT_SYNC] |=> FOOTER_SYNC;
    endproperty
    a_footer_set: assert property (p_footer_set) else $error("footer sync not set"); // RULE6

    property p_fcs_write;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        wr_cfg |=> TX_FCS_CHECK_ENABLE == $past(REG_WDATA[mrcr_pkg::BIT_FCS_CHECK]);
    endproperty
    a_fcs_write: assert property (p_fcs_write) else $error("fcs enable not written"); // RULE9

    property p_zero_write;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        wr_cfg && REG_WDATA[mrcr_pkg::BIT_ZERO_ALIGN] ##1 CHUNK_PROTOCOL |-> START_WORD_OFFSET_ZERO;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero align not applied"); // RULE12

    property p_soft_pulse;
        @(posedge CLK_SYS) disable iff (!RST_B)
        SOFT_RESET_OUT |=> !SOFT_RESET_OUT && !FOOTER_SYNC && RESET_COMPLETE_FLAG
            && CHUNK_SIZE_SELECT == mrcr_pkg::CPS_RST;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset incomplete"); // RULE2

    property p_irq_rst_done;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        rst_done |=> !IRQ_OUT_N;
    endproperty
    a_irq_rst_done: assert property (p_irq_rst_done) else $error("irq missing after reset"); // RULE8

    property p_read_reserved;
        @(posedge CLK_SYS) disable iff (!rst_b_int)
        REG_RD |=> REG_RDATA[31:16] == 16'h0;
    endproperty
    a_read_reserved: assert property (p_read_reserved) else $error("reserved bits set"); // RULE16
endmodule : mrcr_regs

// >>> test/mrcr_host_model.sv
`timescale 1ns/100ps
module mrcr_host_model (
    input wire logic clk,
    input wire logic [31:0] rdata,
    output logic wr,
    output logic rd,
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic cs
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        cs = 1'b0;
    end
    // ----
    // Control command cycles
    // ----
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        wr = w;
        rd = ~w;
        @(posedge clk);
        #1;
        wr = 1'b0;
        rd = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask : xfer
    task automatic read(input logic [7:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h0);
        @(posedge clk);
        #1;
        d = rdata;
    endtask : read
    task automatic set_cs(input logic level);
        @(posedge clk);
        #1;
        cs = level;
    endtask : set_cs
    task automatic soft_reset(input int hold);
        set_cs(1'b1);
        xfer(1'b1, mrcr_pkg::OFS_SOFT_RESET, 32'h1);
        repeat (hold) @(posedge clk);
    endtask : soft_reset
endmodule : mrcr_host_model

// >>> test/macphy_reset_config_regs_tb.sv
`timescale 1ns/100ps
module macphy_reset_config_regs_tb;
    localparam logic [7:0] CFG = mrcr_pkg::OFS_HOST_LINK_CONFIG_0;
    localparam logic [7:0] CAP = mrcr_pkg::OFS_CAPABILITY;
    localparam logic [7:0] SRST = mrcr_pkg::OFS_SOFT_RESET;
    logic clk_sys, rst_b, wr, rd, cs, proto, rc_clr, first, req;
    logic ok, swo0, sync, fcs_en, flag, sr_out, irq_n;
    logic [7:0] addr, credits;
    logic [31:0] wdata, rdata, d;
    logic [2:0] octets, chunk_size_select;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int sr_cnt = 0;
    int base;
    mrcr_host_model mrcr_host_model_i (.clk(clk_sys), .rdata(rdata), .wr(wr), .rd(rd),
        .addr(addr), .wdata(wdata), .cs(cs));
    mrcr_regs mrcr_regs_i (.CLK_SYS(clk_sys), .RST_B(rst_b), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .CS_ACTIVE(cs),
        .CHUNK_PROTOCOL(proto), .RESET_COMPLETE_CLR(rc_clr), .TX_CREDIT_COUNT(credits),
        .FIRST_CHUNK_AFTER_CS(first), .FRAME_START_REQ(req), .FRAME_START_OK(ok),
        .START_WORD_OFFSET_ZERO(swo0), .FOOTER_SYNC(sync), .TX_FCS_CHECK_ENABLE(fcs_en),
        .FCS_OCTETS(octets), .CHUNK_SIZE_SELECT(chunk_size_select), .RESET_COMPLETE_FLAG(flag),
        .SOFT_RESET_OUT(sr_out), .IRQ_OUT_N(irq_n));
    task automatic final_report;
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chkb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        mrcr_host_model_i.read(a, r);
        chk(r, exp);
    endtask : rd_chk
    task automatic put(input logic [7:0] a, input logic [31:0] x);
        mrcr_host_model_i.xfer(1'b1, a, x);
    endtask : put
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_cyc
    task automatic defaults;
        rd_chk(CFG, 32'h6);
        rd_chk(CAP, 32'h3);
        rd_chk(SRST, 32'h0);
        chkb(flag, 1'b1);
        chkb(irq_n, 1'b0);
        chkb(sync, 1'b0);
        chk({29'h0, chunk_size_select}, 32'h6);
    endtask : defaults
    function automatic logic [31:0] exp_cfg(input logic [31:0] x);
        return x & 32'h0000fc07;
    endfunction : exp_cfg
    function automatic logic [7:0] thr(input logic [1:0] c);
        return (c == 2'h0) ? 8'h01 : 8'h01 << ({1'b0, c} + 3'h1);
    endfunction : thr
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (sr_out === 1'b1) begin
            sr_cnt++;
        end
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        rst_b = 1'b0;
        proto = 1'b1;
        rc_clr = 1'b0;
        credits = 8'h00;
        first = 1'b0;
        req = 1'b0;
        void'($urandom(32'he742));
        repeat (5) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        defaults();
        rc_clr = 1'b1;
        wait_cyc(1);
        rc_clr = 1'b0;
        chkb(flag, 1'b0);
        for (int c = 0; c < 4; c++) begin
            put(CFG, 32'(c << 10) | 32'h6);
            credits = thr(2'(c)) - 8'h01;
            wait_cyc(3);
            chkb(irq_n, 1'b1);
            credits = thr(2'(c)) + 8'($urandom % 240);
            wait_cyc(3);
            chkb(irq_n, 1'b0);
        end
        proto = 1'b0;
        wait_cyc(3);
        chkb(irq_n, 1'b1);
        proto = 1'b1;
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            d[15] = 1'b0;
            d[13:12] = 2'(i);
            d[14] = d[13] ^ d[12];
            d[2:0] = 3'h3 + 3'($urandom % 4);
            // size chosen before sync, no CRC append
            put(CFG, d);
            rd_chk(CFG, exp_cfg(d));
            chkb(fcs_en, d[14]);
            chk({29'h0, octets}, d[14] ? 32'h4 : 32'h0);
            chk({29'h0, chunk_size_select}, {29'h0, d[2:0]});
            for (int f = 0; f < 2; f++) begin
                first = f[0];
                req = 1'b1;
                #1;
                chkb(ok, ~d[13] | f[0]);
                chkb(swo0, d[13] | d[12]);
                proto = 1'b0;
                #1;
                chkb(ok, 1'b1);
                proto = 1'b1;
            end
        end
        put(CFG, d | 32'h8000);
        rd_chk(CFG, exp_cfg(d) | 32'h8000);
        chkb(sync, 1'b1);
        put(CFG, d);
        rd_chk(CFG, exp_cfg(d) | 32'h8000);
        chkb(sync, 1'b1);
        put(CAP, 32'hffffffff);
        rd_chk(CAP, 32'h3);
        put(SRST, 32'hfffffffe);
        rd_chk(SRST, 32'h0);
        put(8'h7f, $urandom);
        rd_chk(8'h7f, 32'h0);
        base = sr_cnt;
        mrcr_host_model_i.soft_reset(9);
        mrcr_host_model_i.set_cs(1'b0);
        wait_cyc(20);
        chk(32'(sr_cnt), 32'(base));
        rd_chk(CFG, exp_cfg(d) | 32'h8000);
        mrcr_host_model_i.soft_reset(10);
        chk(32'(sr_cnt), 32'(base));
        mrcr_host_model_i.set_cs(1'b0);
        for (int n = 0; n < 30 && sr_cnt == base; n++) begin
            wait_cyc(1);
        end
        wait_cyc(2);
        chk(32'(sr_cnt), 32'(base + 1));
        defaults();
        final_report();
    end
endmodule : macphy_reset_config_regs_tb
